// ==== core/lcd_common_scan_driver.sv ====
/*
 * Digital core of a 68-output LCD common driver: bidirectional scan
 * shift register with cascade ports and a four-level choice per output.
 * Assumes all controller pins are asynchronous to ref_clk_i and that the
 * shift clock pulses last at least three system clocks; level shifters
 * and bias supplies sit outside and consume the encoded level choices.
 * Chain contents are only meaningful once chain_primed_o has risen;
 * until then the stages hold reset zeros mixed with received bits.
 */
`timescale 1ns/10ps
`include "lcd_common_regs.svh"

module lcd_common_scan_driver (
    // system clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // control pins from the controller
    input wire lcd_common_pkg::ctrl_pins_type ctrl_pins_i,
    // low chain port, two-way
    input wire logic chain_port_low_i,
    output lcd_common_pkg::chain_drive_type chain_port_low_o,
    // high chain port, two-way
    input wire logic chain_port_high_i,
    output lcd_common_pkg::chain_drive_type chain_port_high_o,
    // driver level choices and status
    output lcd_common_pkg::level_vec_type common_outputs_o,
    output logic chain_primed_o
);

    // pin synchronisers, one row per input pin
    // the first flop of a row may go metastable; only the second is read
    logic [`SYNC_DEPTH-1:0] clk_sync_reg;
    logic [`SYNC_DEPTH-1:0] dir_sync_reg;
    logic [`SYNC_DEPTH-1:0] alt_sync_reg;
    logic [`SYNC_DEPTH-1:0] blank_sync_reg;
    logic [`SYNC_DEPTH-1:0] low_sync_reg;
    logic [`SYNC_DEPTH-1:0] high_sync_reg;

    // shift clock history for edge detection
    logic shift_clock_prev_reg;
    logic shift_fall;

    // scan chain, bit k holds stage k+1
    logic [`STAGE_COUNT-1:0] chain_reg;
    logic [`STAGE_COUNT-1:0] chain_next;
    logic serial_in;

    // priming counter
    logic [`PRIME_CNT_WIDTH-1:0] prime_cnt_reg;

    // level choices before the output register
    lcd_common_pkg::level_vec_type level_next;

    // chain port drivers
    lcd_common_pkg::chain_drive_type low_drive_reg;
    lcd_common_pkg::chain_drive_type high_drive_reg;

    // registered level choices
    lcd_common_pkg::level_vec_type common_outputs_reg;

    // one step of a pin synchroniser: first flop takes the pin
    function automatic logic [`SYNC_DEPTH-1:0] sync_step(
        input logic [`SYNC_DEPTH-1:0] hist,
        input logic pin
    );
        return {hist[0], pin};
    endfunction : sync_step

    // control pin synchronisers; only the last flop is read by logic
    // a two-flop delay costs latency but keeps metastability off the chain
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clk_sync_reg <= '0;
            dir_sync_reg <= '0;
            alt_sync_reg <= '0;
            blank_sync_reg <= '0;
        end else begin
            clk_sync_reg <= sync_step(clk_sync_reg, ctrl_pins_i.shift_clock);
            dir_sync_reg <= sync_step(dir_sync_reg,
                ctrl_pins_i.shift_dir_sel);
            alt_sync_reg <= sync_step(alt_sync_reg,
                ctrl_pins_i.frame_alternate);
            blank_sync_reg <= sync_step(blank_sync_reg,
                ctrl_pins_i.display_blank_n);
        end
    end

    // chain port synchronisers; same depth as the shift clock path
    // so data set up at the pins is still in place at the fall
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            low_sync_reg <= '0;
            high_sync_reg <= '0;
        end else begin
            low_sync_reg <= sync_step(low_sync_reg, chain_port_low_i);
            high_sync_reg <= sync_step(high_sync_reg, chain_port_high_i);
        end
    end

    // previous synchronised shift clock; resets low like the sync flops,
    // so a release never looks like a fall and a clock held low counts
    // only once it has been seen high
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shift_clock_prev_reg <= 1'h0;
        end else begin
            shift_clock_prev_reg <= clk_sync_reg[1];
        end
    end

    // falling edge of the shift clock only; rising edges are ignored
    // a level shorter than one system clock may be missed entirely
    assign shift_fall = shift_clock_prev_reg & ~clk_sync_reg[1];

    // serial input comes from whichever port the direction makes an input
    // data and clock pass equal sync depth, so setup at the pins carries
    assign serial_in = dir_sync_reg[1] ? high_sync_reg[1]
                                       : low_sync_reg[1];

    // next chain contents for the current direction
    // only one end is fed; the stage at the other end falls off
    always_comb begin
        if (dir_sync_reg[1]) begin
            // toward stage 1: stage 68 takes the high port
            chain_next = {serial_in, chain_reg[`STAGE_COUNT-1:1]};
        end else begin
            // toward stage 68: stage 1 takes the low port
            chain_next = {chain_reg[`STAGE_COUNT-2:0], serial_in};
        end
    end

    // chain moves one stage per shift clock fall and holds otherwise
    // a direction change between falls applies from the next fall on
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            chain_reg <= '0;
        end else if (shift_fall) begin
            chain_reg <= chain_next;
        end
    end

    // counts falls since reset; contents before that are stale
    // saturates at the chain length, so it never wraps back to zero
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prime_cnt_reg <= '0;
        end else if (shift_fall && prime_cnt_reg != 
                     (`PRIME_CNT_WIDTH)'(`PRIME_SHIFTS)) begin
            prime_cnt_reg <= prime_cnt_reg + 1'h1;
        end
    end

    // stays high until the next reset, whatever the direction does
    assign chain_primed_o = (prime_cnt_reg ==
        (`PRIME_CNT_WIDTH)'(`PRIME_SHIFTS));

    // low port: in reverse shifting it is the far end and drives
    // data moves only with a fall, so it changes with the chain itself
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            low_drive_reg <= '0;
        end else begin
            if (shift_fall) begin
                low_drive_reg.data_out <= chain_next[0];
            end
            low_drive_reg.data_oe <= dir_sync_reg[1];
        end
    end

    // high port: in forward shifting it is the far end and drives
    // the port facing the input is released, never driven
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            high_drive_reg <= '0;
        end else begin
            if (shift_fall) begin
                high_drive_reg.data_out <= chain_next[`STAGE_COUNT-1];
            end
            high_drive_reg.data_oe <= ~dir_sync_reg[1];
        end
    end

    // ports show the flops; a next cascade stage samples them
    // through its own synchronisers, so no extra delay is added here
    assign chain_port_low_o = low_drive_reg;
    assign chain_port_high_o = high_drive_reg;

    // one level chooser per output, output n from stage n
    // plain gates; the output flops below hide any decode glitch
    for (genvar n = 0; n < `STAGE_COUNT; n++) begin : g_level
        bias_level_select u_select (
            .scan_bit_i(chain_reg[n]),
            .frame_alternate_i(alt_sync_reg[1]),
            .display_blank_n_i(blank_sync_reg[1]),
            .level_o(level_next[n])
        );
    end

    // level choices leave through flops; reset shows the blank level
    // one cycle behind the chain, traded for glitch-free level pins
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            common_outputs_reg <= '0;
        end else begin
            common_outputs_reg <= level_next;
        end
    end

    assign common_outputs_o = common_outputs_reg;

endmodule : lcd_common_scan_driver

// ==== core/lcd_common_regs.svh ====
/*
 * Constants for the common scan driver: chain length, pin sampling depth
 * and the timing figures of the shift clock pins.
 * Assumes nothing; included by bare name wherever the figures are needed.
 */
`ifndef LCD_COMMON_REGS_SVH
`define LCD_COMMON_REGS_SVH

// number of shift stages and driver outputs
`define STAGE_COUNT 68
// width of one encoded bias level choice
`define LEVEL_WIDTH 2
// flip-flops every pin passes before logic reads it
`define SYNC_DEPTH 2

// system clock period in ns
`define REF_CLK_PERIOD_NS 50
// least shift clock pulse width in ns
`define SHIFT_PULSE_MIN_NS 125
// least pulse width in whole system clocks, rounded up
`define SHIFT_PULSE_MIN_CYC \
    ((`SHIFT_PULSE_MIN_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

// shifts before the chain holds only received scan data
`define PRIME_SHIFTS 68
// width of the priming counter
`define PRIME_CNT_WIDTH 7

`endif

// ==== core/lcd_common_pkg.sv ====
/*
 * Types shared by the common scan driver and its bias level selector.
 * Assumes the constants header is on the include path.
 */
`include "lcd_common_regs.svh"

package lcd_common_pkg;

    // encoded choice of one of the four bias supplies
    typedef enum logic [`LEVEL_WIDTH-1:0] {
        bias_level_top = 2'h0,
        bias_level_upper_mid = 2'h1,
        bias_level_lower_mid = 2'h2,
        bias_level_bottom = 2'h3
    } level_type;

    // control pins from the LCD controller
    typedef struct packed {
        logic shift_clock;
        logic shift_dir_sel;
        logic frame_alternate;
        logic display_blank_n;
    } ctrl_pins_type;

    // one side of a two-way chain port
    typedef struct packed {
        logic data_out;
        logic data_oe;
    } chain_drive_type;

    // one level choice per common output, output n at index n-1
    typedef logic [`STAGE_COUNT-1:0][`LEVEL_WIDTH-1:0] level_vec_type;

endpackage : lcd_common_pkg

// ==== core/bias_level_select.sv ====
/*
 * Bias level chooser for one common output: maps stored scan bit, frame
 * alternate and blank control onto one of four supply levels.
 * Assumes synchronised inputs; purely combinational, caller registers it.
 */
`timescale 1ns/10ps

module bias_level_select (
    // per-output inputs
    input wire logic scan_bit_i,
    input wire logic frame_alternate_i,
    input wire logic display_blank_n_i,
    // encoded level choice
    output lcd_common_pkg::level_type level_o
);

    // blank forces the top level; otherwise the truth table applies
    always_comb begin
        if (!display_blank_n_i) begin
            level_o = lcd_common_pkg::bias_level_top;
        end else begin
            // low bit is row select on the outer levels
            case ({frame_alternate_i, scan_bit_i})
                2'h0: level_o = lcd_common_pkg::bias_level_upper_mid;
                2'h1: level_o = lcd_common_pkg::bias_level_bottom;
                2'h2: level_o = lcd_common_pkg::bias_level_lower_mid;
                2'h3: level_o = lcd_common_pkg::bias_level_top;
                default: level_o = lcd_common_pkg::bias_level_top;
            endcase
        end
    end

endmodule : bias_level_select

// ==== verif/lcd_common_scan_asserts.sv ====
/* port checker for the common scan driver.
   assumes a bind onto lcd_common_scan_driver, one clock domain. */
`timescale 1ns/10ps
module lcd_common_scan_asserts (
    // clock, reset and controller pins
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire lcd_common_pkg::ctrl_pins_type ctrl_pins_i,
    // driver side
    input wire lcd_common_pkg::chain_drive_type chain_port_low_o,
    input wire lcd_common_pkg::chain_drive_type chain_port_high_o,
    input wire lcd_common_pkg::level_vec_type common_outputs_o,
    input wire logic chain_primed_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    logic [2:0] sc_reg;
    logic fall_w;
    // pin history, so a fall is placed at its update edge
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) sc_reg <= 3'h0;
        else sc_reg <= {sc_reg[1:0], ctrl_pins_i.shift_clock};
    end
    assign fall_w = sc_reg[2] & ~sc_reg[1];
    oe_fwd_a:
    assert property (!ctrl_pins_i.shift_dir_sel [*5] |->
        chain_port_high_o.data_oe && !chain_port_low_o.data_oe)
        else $error("high port not driving");
    oe_rev_a:
    assert property (ctrl_pins_i.shift_dir_sel [*5] |->
        chain_port_low_o.data_oe && !chain_port_high_o.data_oe)
        else $error("low port not driving");
    oe_excl_a:
    assert property (!(chain_port_low_o.data_oe && chain_port_high_o.data_oe))
        else $error("both chain ports driving");
    chain_hold_a:
    assert property (!$past(fall_w) |-> $stable(chain_port_high_o.data_out)
        && $stable(chain_port_low_o.data_out))
        else $error("chain moved without a fall");
    blank_all_a:
    assert property (!ctrl_pins_i.display_blank_n [*4] |->
        common_outputs_o == '0) else $error("blank not at top level");
    top_row_a:
    assert property ((ctrl_pins_i.display_blank_n
        && !ctrl_pins_i.frame_alternate) [*5] |-> common_outputs_o[67] ==
        ($past(chain_port_high_o.data_out) ? 2'h3 : 2'h1))
        else $error("last output level wrong");
    first_row_a:
    assert property ((ctrl_pins_i.display_blank_n
        && ctrl_pins_i.frame_alternate) [*5] |-> common_outputs_o[0] ==
        ($past(chain_port_low_o.data_out) ? 2'h0 : 2'h2))
        else $error("first output level wrong");
    primed_step_a:
    assert property (chain_primed_o != $past(chain_primed_o) |->
        $past(fall_w) && chain_primed_o)
        else $error("primed flag moved badly");
endmodule : lcd_common_scan_asserts

// ==== verif/lcd_ctrl_model.sv ====
/* controller model: drives the control pins and the scan data pin.
   assumes one bench process calls its tasks, never two at once. */
`timescale 1ns/10ps
module lcd_ctrl_model (
    // clock
    input wire logic ref_clk_i,
    // pins toward the driver
    output lcd_common_pkg::ctrl_pins_type ctrl_o,
    output logic data_o
);
    // clock idles high, so reset release sees no edge
    initial begin
        ctrl_o = 4'h9;
        data_o = 1'b0;
    end
    // one scan bit; data inverted once its hold time is over
    task automatic shift_bit(input logic b);
        @(posedge ref_clk_i) data_o <= b;
        repeat (2) @(posedge ref_clk_i);
        ctrl_o.shift_clock <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        ctrl_o.shift_clock <= 1'b1;
        @(posedge ref_clk_i) data_o <= ~b;
    endtask : shift_bit
    // direction shared along a cascade, alternate flipped per frame
    task automatic set_ctrl(input logic dir, input logic alt, input logic bn);
        @(posedge ref_clk_i);
        ctrl_o.shift_dir_sel <= dir;
        ctrl_o.frame_alternate <= alt;
        ctrl_o.display_blank_n <= bn;
    endtask : set_ctrl
endmodule : lcd_ctrl_model

// ==== verif/lcd_common_scan_driver_tb.sv ====
/* bench for the common scan driver against a queue model of the chain.
   assumes the checker and controller model are compiled first. */
`timescale 1ns/10ps
module lcd_common_scan_driver_tb;
    logic ref_clk_i;
    logic nrst_i;
    lcd_common_pkg::ctrl_pins_type ctrl_w;
    lcd_common_pkg::chain_drive_type low_o;
    lcd_common_pkg::chain_drive_type high_o;
    lcd_common_pkg::level_vec_type outs_w;
    logic data_w, primed_w, low_w, high_w;
    logic stg[$];
    int shifts, miscompares, n_checks;
    int cyc = 0;
    // wire level: whichever side enables its driver wins
    assign low_w = low_o.data_oe ? low_o.data_out : data_w;
    assign high_w = high_o.data_oe ? high_o.data_out : data_w;
    lcd_ctrl_model i_lcd_ctrl_model (.ref_clk_i(ref_clk_i),
        .ctrl_o(ctrl_w), .data_o(data_w));
    lcd_common_scan_driver i_lcd_common_scan_driver (.ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i), .ctrl_pins_i(ctrl_w), .chain_port_low_i(low_w),
        .chain_port_low_o(low_o), .chain_port_high_i(high_w),
        .chain_port_high_o(high_o), .common_outputs_o(outs_w),
        .chain_primed_o(primed_w));
    // 20 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    // hang guard, well above the roughly 1700 cycles needed
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc > 10000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic cmp(input string what, input logic [1:0] e, got);
        n_checks++;
        if (got !== e) begin
            miscompares++;
            $display("[ERR] %s expected %0h seen %0h", what, e, got);
        end
    endtask : cmp
    // expected level from the pins as driven now
    function automatic logic [1:0] lvl(input logic b);
        if (!ctrl_w.display_blank_n) return 2'h0;
        if (ctrl_w.frame_alternate) return b ? 2'h0 : 2'h2;
        return b ? 2'h3 : 2'h1;
    endfunction : lvl
    // wait out sync and output flops, sample away from the edge
    task automatic check_all();
        repeat (4) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        for (int n = 0; n < 68; n++)
            cmp("level", lvl(stg[n]), outs_w[n]);
        cmp("high out", stg[67], high_o.data_out);
        cmp("low out", stg[0], low_o.data_out);
        cmp("high oe", !ctrl_w.shift_dir_sel, high_o.data_oe);
        cmp("primed", shifts >= 68, primed_w);
    endtask : check_all
    task automatic push(input logic b);
        i_lcd_ctrl_model.shift_bit(b);
        shifts++;
        if (ctrl_w.shift_dir_sel) begin
            stg.push_back(b);
            void'(stg.pop_front());
        end else begin
            stg.push_front(b);
            void'(stg.pop_back());
        end
    endtask : push
    task automatic do_reset();
        @(posedge ref_clk_i) nrst_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        stg = {};
        repeat (68) stg.push_back(1'b0);
        shifts = 0;
    endtask : do_reset
    initial begin
        nrst_i = 1'b0;
        miscompares = 0;
        n_checks = 0;
        void'($urandom(32'hC4D23892));
        do_reset();
        check_all();
        // past 68 shifts, so received bits leave the far end
        for (int i = 0; i < 75; i++) begin
            push(1'($urandom));
            check_all();
        end
        i_lcd_ctrl_model.set_ctrl(1'b1, 1'b1, 1'b1);
        for (int i = 0; i < 72; i++) begin
            push(1'($urandom));
            check_all();
        end
        // every alternate and blank pairing on the held pattern
        for (int i = 0; i < 4; i++) begin
            i_lcd_ctrl_model.set_ctrl(1'($urandom), i[0], i[1]);
            check_all();
        end
        // reset in mid-run clears chain and primed flag
        do_reset();
        check_all();
        end_sim();
    end
endmodule : lcd_common_scan_driver_tb
bind lcd_common_scan_driver lcd_common_scan_asserts i_asserts (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ctrl_pins_i(ctrl_pins_i),
    .chain_port_low_o(chain_port_low_o),
    .chain_port_high_o(chain_port_high_o),
    .common_outputs_o(common_outputs_o), .chain_primed_o(chain_primed_o));
